//--- hw/acr_pkg.sv
// Shared constants and types for the converter control and result register block.
package acr_pkg;

    // Bus geometry.
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // Register byte offsets.
    localparam logic [7:0] OFF_CONTROL_0     = 8'h00;
    localparam logic [7:0] OFF_CONTROL_1     = 8'h04;
    localparam logic [7:0] OFF_TRIGGER       = 8'h08;
    localparam logic [7:0] OFF_RESULT_HIGH   = 8'h0C;
    localparam logic [7:0] OFF_RESULT_LOW    = 8'h10;
    localparam logic [7:0] OFF_STATUS        = 8'h14;

    // Field positions in the first control register.
    localparam int unsigned CHANNEL_LSB      = 2;
    localparam int unsigned GO_BIT           = 1;
    localparam int unsigned ENABLE_BIT       = 0;

    // Field positions in the second control register.
    localparam int unsigned FORMAT_BIT       = 7;
    localparam int unsigned CLKSEL_LSB       = 4;
    localparam int unsigned NEGREF_BIT       = 2;
    localparam int unsigned POSREF_LSB       = 0;

    // Field positions in the status register.
    localparam int unsigned DONE_BIT         = 0;
    localparam int unsigned BUSY_BIT         = 1;

    // Values after reset and writable masks.
    localparam logic [7:0] CONTROL_0_RESET   = 8'h00;
    localparam logic [7:0] CONTROL_1_RESET   = 8'h00;
    localparam logic [7:0] TRIGGER_RESET     = 8'h00;
    localparam logic [7:0] CONTROL_1_MASK    = 8'hF7;
    localparam logic [7:0] TRIGGER_MASK      = 8'h1F;

    // Input channel codes.
    localparam logic [5:0] CH_FIXED_REF      = 6'h3F;
    localparam logic [5:0] CH_REF_OUTPUT     = 6'h3E;
    localparam logic [5:0] CH_TEMPERATURE    = 6'h3D;
    localparam logic [5:0] CH_GROUND         = 6'h3C;
    localparam logic [5:0] CH_PORT_A_LAST    = 6'h05;
    localparam logic [5:0] CH_PORT_A_GAP     = 6'h03;
    localparam logic [5:0] CH_PORT_B_FIRST   = 6'h0C;
    localparam logic [5:0] CH_PORT_C_LAST    = 6'h17;

    // Conversion clock select codes and their system clock divisors.
    localparam logic [2:0] CLK_DIV2          = 3'h0;
    localparam logic [2:0] CLK_DIV8          = 3'h1;
    localparam logic [2:0] CLK_DIV32         = 3'h2;
    localparam logic [2:0] CLK_RC_A          = 3'h3;
    localparam logic [2:0] CLK_DIV4          = 3'h4;
    localparam logic [2:0] CLK_DIV16         = 3'h5;
    localparam logic [2:0] CLK_DIV64         = 3'h6;
    localparam logic [2:0] CLK_RC_B          = 3'h7;
    localparam logic [6:0] DIVISOR_2         = 7'h02;
    localparam logic [6:0] DIVISOR_4         = 7'h04;
    localparam logic [6:0] DIVISOR_8         = 7'h08;
    localparam logic [6:0] DIVISOR_16        = 7'h10;
    localparam logic [6:0] DIVISOR_32        = 7'h20;
    localparam logic [6:0] DIVISOR_64        = 7'h40;

    // Reference codes.
    localparam logic [1:0] POSREF_SUPPLY     = 2'h0;
    localparam logic [1:0] POSREF_RESERVED   = 2'h1;
    localparam logic [1:0] POSREF_EXT_PIN    = 2'h2;
    localparam logic [1:0] POSREF_FIXED      = 2'h3;

    // Trigger sources, indexed by their selection code; index 0 means none.
    localparam int unsigned TRIG_COUNT       = 18;
    localparam logic [4:0] TRIG_NONE         = 5'h00;
    localparam logic [4:0] TRIG_LAST         = 5'h11;

    // Bus responses.
    localparam logic [1:0] RESP_OKAY         = 2'h0;
    localparam logic [1:0] RESP_SLVERR       = 2'h2;

    // Steering toward the analog converter core.
    typedef struct packed {
        logic       enable;
        logic       muxConnect;
        logic [5:0] channel;
        logic [1:0] posRef;
        logic       negRefExternal;
        logic       useRcOscillator;
    } acr_analog_ctrl_t;

endpackage

//--- hw/acr_top.sv
// Converter control, trigger and result registers behind an AXI4-Lite slave.
//
// Behaviour
// [RQ1] Six-bit channel field, top codes internal, gaps unconnected.
// [RQ2] Port pins A, B4-7, C0-7 selected by code.
// [RQ3] Writing go starts conversion; reads one while busy.
// [RQ4] Hardware clears go when conversion finishes.
// [RQ5] Enable bit powers converter; zero draws no current.
// [RQ6] Right format zeroes six upper high bits.
// [RQ7] Left format zeroes six lower low bits.
// [RQ8] Clock code picks divide 2..64 or RC.
// [RQ9] Negative reference: ground at zero, pin at one.
// [RQ10] Enable zero disconnects every multiplexer input.
// [RQ11] Positive reference: supply, pin, fixed; 01 reserved.
// [RQ12] Trigger zero none; logic cells, capture units.
// [RQ13] Timer, comparator and timer overflow trigger codes.
// [RQ14] Trigger sources act on rising edges.
// [RQ15] Overflow triggers coincide with timer flag setting.
// [RQ16] Left format: high 9..2, low top 1..0.
// [RQ17] Right format: high low bits hold 9..8.
// [RQ18] Right format: low byte holds 7..0.
// [RQ19] Trigger edge sets go by hardware.
// [RQ20] Completion sets done flag, loads both result bytes.
// [RQ21] Reset clears registers, stops converter, abandons conversion.
// [RQ22] Go write ignored while converter disabled.
// [RQ23] Result bytes unreset; control registers reset zero.
`timescale 1ns/100ps
`default_nettype none

module acr_top (
    // Clock and reset.
    input  wire logic                        clk,
    input  wire logic                        rst,
    // AXI4-Lite write address channel.
    input  wire logic [acr_pkg::ADDR_W-1:0]  awaddr,
    input  wire logic [2:0]                  awprot,
    input  wire logic                        awvalid,
    output logic                             awready,
    // AXI4-Lite write data channel.
    input  wire logic [acr_pkg::DATA_W-1:0]  wdata,
    input  wire logic [3:0]                  wstrb,
    input  wire logic                        wvalid,
    output logic                             wready,
    // AXI4-Lite write response channel.
    output logic [1:0]                       bresp,
    output logic                             bvalid,
    input  wire logic                        bready,
    // AXI4-Lite read address channel.
    input  wire logic [acr_pkg::ADDR_W-1:0]  araddr,
    input  wire logic [2:0]                  arprot,
    input  wire logic                        arvalid,
    output logic                             arready,
    // AXI4-Lite read data channel.
    output logic [acr_pkg::DATA_W-1:0]       rdata,
    output logic [1:0]                       rresp,
    output logic                             rvalid,
    input  wire logic                        rready,
    // Trigger sources from neighbouring peripherals on this clock.
    input  wire logic [acr_pkg::TRIG_COUNT-1:0] triggerSources,
    // Analog converter core.
    output acr_pkg::acr_analog_ctrl_t        analogCtrl,
    output logic                             conversionClockTick,
    output logic                             coreStart,
    input  wire logic                        coreDone,
    input  wire logic [9:0]                  coreResult,
    // Completion flag toward the interrupt controller.
    output logic                             conversionDoneFlag
);

    // Stored register fields.
    logic [5:0] inputChannelSelect;
    logic       go;
    logic       converterEnable;
    logic       resultFormat;
    logic [2:0] conversionClockSelect;
    logic       negativeReferenceSelect;
    logic [1:0] positiveReferenceSelect;
    logic [4:0] autoTriggerSelect;
    logic [7:0] resultHighByte;
    logic [7:0] resultLowByte;

    // Bus slave state.
    logic                        awHeld;
    logic                        wHeld;
    logic [acr_pkg::ADDR_W-1:0]  writeAddr;
    logic [7:0]                  writeByte;
    logic                        writeLane0;
    logic                        doWrite;
    logic                        readTaken;
    logic [7:0]                  readValue;
    logic                        readMapped;

    // Conversion control.
    logic [acr_pkg::TRIG_COUNT-1:0] triggerPrev;
    logic [acr_pkg::TRIG_COUNT-1:0] triggerRise;
    logic       triggerEdge;
    logic       softwareStart;
    logic       softwareStop;
    logic       startRequest;
    logic       conversionFinish;
    logic       doneClear;
    logic [5:0] divCount;
    logic [6:0] divisor;
    logic       useRc;
    logic       channelValid;

    // Write channel: address and data are taken independently.
    assign awready = !awHeld && !bvalid;
    assign wready  = !wHeld && !bvalid;
    assign doWrite = awHeld && wHeld && !bvalid;

    always_ff @(posedge clk) begin
        if (rst) begin
            awHeld    <= 1'b0;
            writeAddr <= '0;
        end else if (awvalid && awready) begin
            awHeld    <= 1'b1;
            writeAddr <= awaddr;
        end else if (doWrite) begin
            awHeld    <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wHeld      <= 1'b0;
            writeByte  <= 8'h00;
            writeLane0 <= 1'b0;
        end else if (wvalid && wready) begin
            wHeld      <= 1'b1;
            writeByte  <= wdata[7:0];
            writeLane0 <= wstrb[0];
        end else if (doWrite) begin
            wHeld      <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bvalid <= 1'b0;
            bresp  <= acr_pkg::RESP_OKAY;
        end else if (doWrite) begin
            bvalid <= 1'b1;
            bresp  <= isMapped(writeAddr) ? acr_pkg::RESP_OKAY : acr_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    function automatic logic isMapped(input logic [acr_pkg::ADDR_W-1:0] addr);
        unique case (addr)
            acr_pkg::OFF_CONTROL_0, acr_pkg::OFF_CONTROL_1, acr_pkg::OFF_TRIGGER,
            acr_pkg::OFF_RESULT_HIGH, acr_pkg::OFF_RESULT_LOW,
            acr_pkg::OFF_STATUS: isMapped = 1'b1;
            default: isMapped = 1'b0;
        endcase
    endfunction

    function automatic logic hits(input logic [7:0] offset);
        hits = doWrite && writeLane0 && (writeAddr == offset);
    endfunction

    // Read channel: data is latched on the address handshake.
    assign arready   = !rvalid;
    assign readTaken = arvalid && arready;

    always_comb begin
        readValue  = 8'h00;
        readMapped = 1'b1;
        unique case (araddr)
            acr_pkg::OFF_CONTROL_0:   readValue = {inputChannelSelect, go, converterEnable};
            acr_pkg::OFF_CONTROL_1:   readValue = {resultFormat, conversionClockSelect, 1'b0,
                                                   negativeReferenceSelect,
                                                   positiveReferenceSelect};
            acr_pkg::OFF_TRIGGER:     readValue = {3'h0, autoTriggerSelect};
            acr_pkg::OFF_RESULT_HIGH: readValue = resultHighByte;
            acr_pkg::OFF_RESULT_LOW:  readValue = resultLowByte;
            acr_pkg::OFF_STATUS:      readValue = {6'h00, go, conversionDoneFlag};
            default:                  readMapped = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid <= 1'b0;
            rdata  <= '0;
            rresp  <= acr_pkg::RESP_OKAY;
        end else if (readTaken) begin
            rvalid <= 1'b1;
            rdata  <= {24'h000000, readValue};
            rresp  <= readMapped ? acr_pkg::RESP_OKAY : acr_pkg::RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // Configuration registers; all return to zero on reset.
    always_ff @(posedge clk) begin
        if (rst) begin
            inputChannelSelect <= acr_pkg::CONTROL_0_RESET[7:2]; // [RQ21] [RQ23]
            converterEnable    <= acr_pkg::CONTROL_0_RESET[0]; // [RQ21]
        end else if (hits(acr_pkg::OFF_CONTROL_0)) begin
            inputChannelSelect <= writeByte[acr_pkg::CHANNEL_LSB +: 6]; // [RQ1]
            converterEnable    <= writeByte[acr_pkg::ENABLE_BIT]; // [RQ5]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            resultFormat            <= acr_pkg::CONTROL_1_RESET[7]; // [RQ23]
            conversionClockSelect   <= acr_pkg::CONTROL_1_RESET[6:4];
            negativeReferenceSelect <= acr_pkg::CONTROL_1_RESET[2];
            positiveReferenceSelect <= acr_pkg::CONTROL_1_RESET[1:0];
        end else if (hits(acr_pkg::OFF_CONTROL_1)) begin
            resultFormat            <= writeByte[acr_pkg::FORMAT_BIT];
            conversionClockSelect   <= writeByte[acr_pkg::CLKSEL_LSB +: 3]; // [RQ8]
            negativeReferenceSelect <= writeByte[acr_pkg::NEGREF_BIT]; // [RQ9]
            positiveReferenceSelect <= writeByte[acr_pkg::POSREF_LSB +: 2]; // [RQ11]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            autoTriggerSelect <= acr_pkg::TRIGGER_RESET[4:0]; // [RQ23]
        end else if (hits(acr_pkg::OFF_TRIGGER)) begin
            autoTriggerSelect <= writeByte[4:0] & acr_pkg::TRIGGER_MASK[4:0]; // [RQ12]
        end
    end

    // Trigger edge detection. Sources share this clock, so no synchroniser is needed;
    // an overflow source pulses in the cycle its timer sets its flag.
    always_ff @(posedge clk) begin
        if (rst) begin
            triggerPrev <= '0;
        end else begin
            triggerPrev <= triggerSources;
        end
    end

    assign triggerRise = triggerSources & ~triggerPrev; // [RQ14] [RQ15]
    assign triggerEdge = (autoTriggerSelect != acr_pkg::TRIG_NONE) &&
                         (autoTriggerSelect <= acr_pkg::TRIG_LAST) &&
                         triggerRise[autoTriggerSelect]; // [RQ12] [RQ13]

    // Start and stop requests; the enable is the stored value, so one write cannot
    // both power the converter and start it.
    assign softwareStart    = hits(acr_pkg::OFF_CONTROL_0) && writeByte[acr_pkg::GO_BIT];
    assign softwareStop     = hits(acr_pkg::OFF_CONTROL_0) &&
                              (!writeByte[acr_pkg::GO_BIT] || !writeByte[acr_pkg::ENABLE_BIT]);
    assign startRequest     = converterEnable && !go &&
                              (softwareStart || triggerEdge); // [RQ22] [RQ19]
    assign conversionFinish = go && converterEnable && coreDone;

    always_ff @(posedge clk) begin
        if (rst) begin
            go <= acr_pkg::CONTROL_0_RESET[1]; // [RQ21]
        end else if (startRequest) begin
            go <= 1'b1; // [RQ3] [RQ19]
        end else if (conversionFinish || softwareStop || !converterEnable) begin
            go <= 1'b0; // [RQ4]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            coreStart <= 1'b0;
        end else begin
            coreStart <= startRequest; // [RQ3]
        end
    end

    // Completion flag, cleared by writing one to its status bit; a completion in the
    // same cycle wins so that no conversion goes unreported.
    assign doneClear = hits(acr_pkg::OFF_STATUS) && writeByte[acr_pkg::DONE_BIT];

    always_ff @(posedge clk) begin
        if (rst) begin
            conversionDoneFlag <= 1'b0;
        end else if (conversionFinish) begin
            conversionDoneFlag <= 1'b1; // [RQ20]
        end else if (doneClear) begin
            conversionDoneFlag <= 1'b0;
        end
    end

    // Result bytes have no reset, so their contents survive a warm reset.
    always_ff @(posedge clk) begin
        if (conversionFinish) begin
            if (resultFormat) begin
                resultHighByte <= {6'h00, coreResult[9:8]}; // [RQ6] [RQ17] [RQ20] [RQ23]
                resultLowByte  <= coreResult[7:0]; // [RQ18]
            end else begin
                resultHighByte <= coreResult[9:2]; // [RQ16] [RQ20]
                resultLowByte  <= {coreResult[1:0], 6'h00}; // [RQ7] [RQ16]
            end
        end else begin
            if (hits(acr_pkg::OFF_RESULT_HIGH)) begin
                resultHighByte <= writeByte;
            end
            if (hits(acr_pkg::OFF_RESULT_LOW)) begin
                resultLowByte <= writeByte;
            end
        end
    end

    // Conversion clock divider; the tick runs only while a conversion is under way.
    always_comb begin
        useRc   = 1'b0;
        divisor = acr_pkg::DIVISOR_2;
        unique case (conversionClockSelect)
            acr_pkg::CLK_DIV2:  divisor = acr_pkg::DIVISOR_2; // [RQ8]
            acr_pkg::CLK_DIV8:  divisor = acr_pkg::DIVISOR_8;
            acr_pkg::CLK_DIV32: divisor = acr_pkg::DIVISOR_32;
            acr_pkg::CLK_DIV4:  divisor = acr_pkg::DIVISOR_4;
            acr_pkg::CLK_DIV16: divisor = acr_pkg::DIVISOR_16;
            acr_pkg::CLK_DIV64: divisor = acr_pkg::DIVISOR_64;
            acr_pkg::CLK_RC_A, acr_pkg::CLK_RC_B: useRc = 1'b1; // [RQ8]
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst || !go || useRc) begin
            divCount <= 6'h00;
        end else if (divCount == 6'(divisor - 7'h01)) begin
            divCount <= 6'h00;
        end else begin
            divCount <= divCount + 6'h01;
        end
    end

    assign conversionClockTick = go && !useRc && (divCount == 6'(divisor - 7'h01)); // [RQ8]

    // Channel decode: reserved codes leave the multiplexer open.
    always_comb begin
        channelValid = 1'b0;
        if (inputChannelSelect >= acr_pkg::CH_GROUND) begin
            channelValid = 1'b1; // [RQ1]
        end else if (inputChannelSelect <= acr_pkg::CH_PORT_A_LAST) begin
            channelValid = (inputChannelSelect != acr_pkg::CH_PORT_A_GAP); // [RQ2]
        end else if (inputChannelSelect >= acr_pkg::CH_PORT_B_FIRST &&
                     inputChannelSelect <= acr_pkg::CH_PORT_C_LAST) begin
            channelValid = 1'b1; // [RQ2]
        end
    end

    always_comb begin
        analogCtrl.enable          = converterEnable; // [RQ5]
        analogCtrl.muxConnect      = converterEnable && channelValid; // [RQ10]
        analogCtrl.channel         = inputChannelSelect;
        analogCtrl.posRef          = positiveReferenceSelect; // [RQ11]
        analogCtrl.negRefExternal  = negativeReferenceSelect; // [RQ9]
        analogCtrl.useRcOscillator = useRc;
    end

endmodule
`default_nettype wire

//--- sim/acr_top_sva.sv
// Checker for the steering, start and completion outputs of the converter block.
`timescale 1ns/100ps
`default_nettype none
module acr_top_sva (
    // Clock and reset.
    input wire logic                      clk,
    input wire logic                      rst,
    // Watched ports.
    input wire acr_pkg::acr_analog_ctrl_t analogCtrl,
    input wire logic                      conversionClockTick,
    input wire logic                      coreStart,
    input wire logic                      coreDone,
    input wire logic                      conversionDoneFlag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_muxOff;
        !analogCtrl.enable |-> !analogCtrl.muxConnect;
    endproperty
    a_muxOff: assert property (p_muxOff) else $error("input connected while off");
    property p_muxGap;
        analogCtrl.muxConnect |->
            !(analogCtrl.channel inside {6'h03, [6'h06:6'h0B], [6'h18:6'h3B]});
    endproperty
    a_muxGap: assert property (p_muxGap) else $error("reserved channel connected");
    property p_rstState;
        $past(rst) |-> analogCtrl == 12'h000 && !coreStart && !conversionDoneFlag;
    endproperty
    a_rstState: assert property (p_rstState) else $error("state after reset");
    property p_doneCause;
        $rose(conversionDoneFlag) |-> $past(coreDone);
    endproperty
    a_doneCause: assert property (p_doneCause) else $error("flag set without done");
    property p_startEnabled;
        coreStart |-> $past(analogCtrl.enable);
    endproperty
    a_startEnabled: assert property (p_startEnabled) else $error("start while off");
    property p_startPulse;
        coreStart |=> !coreStart [*2];
    endproperty
    a_startPulse: assert property (p_startPulse) else $error("start repeated");
    property p_tickGap;
        conversionClockTick |=> !conversionClockTick;
    endproperty
    a_tickGap: assert property (p_tickGap) else $error("tick too close");
    property p_tickSource;
        conversionClockTick |-> analogCtrl.enable && !analogCtrl.useRcOscillator;
    endproperty
    a_tickSource: assert property (p_tickSource) else $error("tick while off or on RC");
    c_start: cover property (coreStart);
    c_done: cover property ($rose(conversionDoneFlag));
    c_tick: cover property (conversionClockTick);
endmodule
`default_nettype wire

//--- sim/acr_core_model.sv
// Behavioural analog core: answers each start with one done pulse.
`timescale 1ns/100ps
`default_nettype none
module acr_core_model (
    // Clock and controls.
    input wire logic       clk,
    input wire logic       coreStart,
    input wire logic       slow,
    input wire logic [9:0] sample,
    // Answer toward the block.
    output logic           coreDone,
    output logic [9:0]     coreResult
);
    int cnt = 0;
    initial begin
        coreDone = 1'h0;
        coreResult = 10'h000;
    end
    // Off the done cycle the result bus toggles, so a late sample is caught.
    always @(posedge clk) begin
        coreDone <= 1'h0;
        coreResult <= ~coreResult;
        if (coreStart) begin
            cnt <= slow ? 40 : 3;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end else if (cnt == 1) begin
            cnt <= 0;
            coreDone <= 1'h1;
            coreResult <= sample;
        end
    end
endmodule
`default_nettype wire

//--- sim/tb_acr_top.sv
// Self-checking bench for the converter control and result registers.
`timescale 1ns/100ps
`default_nettype none
module tb_acr_top;
    logic                      clk = 1'h0, rst = 1'h1, slow = 1'h0, f;
    logic [7:0]                awaddr = 8'h00, araddr = 8'h00;
    logic [31:0]               wdata = 32'h00000000, rdata;
    logic                      awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic                      arvalid = 1'h0, rready = 1'h0;
    logic                      awready, wready, bvalid, arready, rvalid;
    logic                      coreDone, coreStart, tick, doneFlag;
    logic [1:0]                bresp, rresp;
    logic [17:0]               trig = 18'h00000;
    logic [9:0]                coreResult, r, sample = 10'h000;
    acr_pkg::acr_analog_ctrl_t ana;
    logic [33:0]               expQ[$];
    int                        failures = 0, n_checks = 0, cyc = 0;

    acr_top u_acr_top (.clk(clk), .rst(rst), .awaddr(awaddr), .awprot(3'h0),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .triggerSources(trig), .analogCtrl(ana),
        .conversionClockTick(tick), .coreStart(coreStart), .coreDone(coreDone),
        .coreResult(coreResult), .conversionDoneFlag(doneFlag));
    acr_core_model u_acr_core_model (.clk(clk), .coreStart(coreStart), .slow(slow),
        .sample(sample), .coreDone(coreDone), .coreResult(coreResult));

    initial forever #2 clk = ~clk;

    task automatic end_of_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [33:0] got, input logic [33:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    always @(posedge clk) if (rvalid && rready) check({rresp, rdata}, expQ.pop_front(), "read");

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            $display("MISMATCH t=%0t timeout", $time);
            end_of_test();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
        logic ta, tw;
        ta = 1'h0;
        tw = 1'h0;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!(ta && tw)) begin
            @(negedge clk);
            ta = ta || awready;
            tw = tw || wready;
            @(posedge clk);
            if (ta) awvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
        end
        do @(negedge clk); while (!bvalid);
        check(bresp, er, "bresp");
        @(posedge clk);
        bready <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
        expQ.push_back({er, 24'h000000, d});
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(negedge clk); while (!arready);
        @(posedge clk);
        arvalid <= 1'h0;
        do @(negedge clk); while (!rvalid);
        @(posedge clk);
        rready <= 1'h0;
    endtask

    task automatic waitDone;
        do @(negedge clk); while (!doneFlag);
    endtask

    initial begin
        void'($urandom(81965));
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        rd(acr_pkg::OFF_CONTROL_0, 8'h00);
        rd(acr_pkg::OFF_CONTROL_1, 8'h00);
        rd(acr_pkg::OFF_TRIGGER, 8'h00);
        rd(8'h18, 8'h00, acr_pkg::RESP_SLVERR);
        wr(8'h18, 8'h55, acr_pkg::RESP_SLVERR);
        $display("test reset done");
        for (int c = 0; c < 8; c++) begin
            wr(acr_pkg::OFF_CONTROL_1, {c[0], c[2:0], 1'h1, c[1], c[1:0]});
            rd(acr_pkg::OFF_CONTROL_1, {c[0], c[2:0], 1'h0, c[1], c[1:0]});
            check(ana.useRcOscillator, c[1:0] == 2'h3, "rc");
            check(ana.negRefExternal, c[1], "negref");
            check(ana.posRef, c[1:0], "posref");
        end
        $display("test config done");
        wr(acr_pkg::OFF_CONTROL_0, 8'h06);
        rd(acr_pkg::OFF_CONTROL_0, 8'h04);
        check(ana.enable, 1'h0, "enable");
        for (int ch = 0; ch < 64; ch++) begin
            wr(acr_pkg::OFF_CONTROL_0, {ch[5:0], 2'h1});
            check(ana.muxConnect, (ch < 6 && ch != 3) ||
                  (ch > 11 && ch < 24) || ch > 59, "mux");
        end
        $display("test channel done");
        for (int i = 0; i < 4; i++) begin
            f = i[0];
            r = 10'($urandom);
            slow <= i[1];
            sample <= r;
            wr(acr_pkg::OFF_CONTROL_1, {f, 7'h00});
            wr(acr_pkg::OFF_CONTROL_0, 8'hFF);
            if (i[1]) rd(acr_pkg::OFF_CONTROL_0, 8'hFF);
            waitDone();
            rd(acr_pkg::OFF_CONTROL_0, 8'hFD);
            rd(acr_pkg::OFF_STATUS, 8'h01);
            rd(acr_pkg::OFF_RESULT_HIGH, f ? {6'h00, r[9:8]} : r[9:2]);
            rd(acr_pkg::OFF_RESULT_LOW, f ? r[7:0] : {r[1:0], 6'h00});
            wr(acr_pkg::OFF_STATUS, 8'h01);
            rd(acr_pkg::OFF_STATUS, 8'h00);
        end
        $display("test convert done");
        for (int t = 0; t < 18; t++) begin
            wr(acr_pkg::OFF_TRIGGER, {3'h7, t[4:0]});
            rd(acr_pkg::OFF_TRIGGER, {3'h0, t[4:0]});
            trig <= ~(18'h00001 << t);
            repeat (8) @(negedge clk);
            check(doneFlag, 1'h0, "stray");
            if (t > 0) begin
                @(posedge clk);
                trig <= 18'h3FFFF;
                rd(acr_pkg::OFF_STATUS, 8'h02);
                waitDone();
                check(doneFlag, 1'h1, "trig");
                wr(acr_pkg::OFF_STATUS, 8'h01);
                repeat (60) @(negedge clk);
                check(doneFlag, 1'h0, "level");
            end
            @(posedge clk);
            trig <= 18'h00000;
        end
        $display("test trigger done");
        wr(acr_pkg::OFF_TRIGGER, 8'h00);
        wr(acr_pkg::OFF_CONTROL_0, 8'hFF);
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        rd(acr_pkg::OFF_CONTROL_0, 8'h00);
        check(ana, 12'h000, "off");
        repeat (50) @(posedge clk);
        rd(acr_pkg::OFF_STATUS, 8'h00);
        rd(acr_pkg::OFF_RESULT_LOW, r[7:0]);
        $display("test midreset done");
        end_of_test();
    end
endmodule
bind acr_top acr_top_sva u_acr_top_sva (.clk(clk), .rst(rst), .analogCtrl(analogCtrl),
    .conversionClockTick(conversionClockTick), .coreStart(coreStart),
    .coreDone(coreDone), .conversionDoneFlag(conversionDoneFlag));
`default_nettype wire
